// *** design/serial_pkg.sv ***
`default_nettype none
package serial_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_MIN = 1200;
    localparam int BAUD_MAX = 961_200;
    localparam int BAUD_RST = 115_200;
    localparam int DIV_W = 18;
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(CLK_HZ / BAUD_RST);
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC = CLK_HZ / MS_PER_S;
    localparam int AW = 3;
    localparam logic [AW-1:0] REG_CFG = 3'h0;
    localparam logic [AW-1:0] REG_DATA = 3'h1;
    localparam logic [AW-1:0] REG_STAT = 3'h2;
    localparam logic [AW-1:0] REG_IRQ = 3'h3;
    localparam logic [AW-1:0] REG_MASK = 3'h4;
    localparam logic [AW-1:0] REG_ESC = 3'h5;
    localparam logic [AW-1:0] REG_LINE = 3'h5;
    localparam logic [AW-1:0] REG_CALL = 3'h6;
    localparam logic [AW-1:0] REG_MODE = 3'h7;
    localparam int CALL_RING = 0;
    localparam int CALL_RESULT = 1;
    localparam int CALL_OK = 2;
    localparam int CALL_HANGUP = 3;
    localparam int IRQ_W = 7;
    localparam int IRQ_RX = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_DIAL = 2;
    localparam int IRQ_ESC = 3;
    localparam int IRQ_DSR = 4;
    localparam int IRQ_MODE = 5;
    localparam int IRQ_RING = 6;
    localparam logic [7:0] ESC_RST = 8'h2b;
    localparam logic [1:0] ESC_COUNT = 2'h3;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CASE_MASK = 8'hdf;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
    typedef enum logic [1:0] {PWR_IDLE, PWR_CONNECTABLE, PWR_DISCOVERABLE, PWR_OPEN} pwr_mode_t;

    typedef struct packed {
        logic dsr_cmd;
        logic ri_poll;
        logic hs;
        logic echo;
        logic dce;
        logic flow;
        logic stop2;
        parity_t par;
        logic [DIV_W-1:0] div;
    } cfg_t;

    localparam cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, PAR_NONE, DIV_RST};

    typedef struct packed {
        logic [15:0] delay_ms;
        pwr_mode_t next;
        pwr_mode_t start;
    } mode_t;

    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
        clamp_div = (d < DIV_MIN) ? DIV_MIN : ((d > DIV_MAX) ? DIV_MAX : d);
    endfunction

    function automatic logic [3:0] frame_len(input parity_t p, input logic s2);
        frame_len = 4'ha + {3'h0, p != PAR_NONE} + {3'h0, s2};
    endfunction

    function automatic logic par_bit(input parity_t p, input logic [7:0] d);
        par_bit = (p == PAR_ODD) ? ~^d : ((p == PAR_EVEN) ? ^d : 1'b1);
    endfunction

    function automatic logic [7:0] resp_char(input logic ok, input logic [2:0] i);
        logic [55:0] s;
        s = ok ? {8'h4f, 8'h4b, 8'h0d, 8'h0a, 24'h0} : {8'h45, 8'h52, 8'h52, 8'h4f, 8'h52, 8'h0d, 8'h0a};
        resp_char = s[55 - 8 * i -: 8];
    endfunction

    function automatic logic [2:0] resp_last(input logic ok);
        resp_last = ok ? 3'h3 : 3'h6;
    endfunction
endpackage
`default_nettype wire

// *** design/serial_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface serial_if;
    logic txd;
    logic rxd;
    logic rts_b;
    logic cts_b;
    logic dsr_b;
    logic ring_indicate_out;

    modport device (output txd, output rts_b, output ring_indicate_out, input rxd, input cts_b, input dsr_b);
    modport host (input txd, input rts_b, input ring_indicate_out, output rxd, output cts_b, output dsr_b);
endinterface
`default_nettype wire

// *** design/serial_device.sv ***
// Function
// - configurable rate, parity, stop bits, flow control
// - load power-up settings from flash defaults
// - both ends use two-way request/clear flow
// - request-to-send output asserted low
// - clear-to-send input asserted low
// - host transmits into device receive line
// - data-set-ready low active, fed by host
// - host holds data-set-ready during high-speed link
// - high-speed dsr drop ends link or command
// - ring output signals incoming call in communication equipment role
// - ring line may follow call continuously
// - bit rate limited to 1200..961200 baud
// - selectable terminal or communication equipment role
// - escape character is programmable
// - command echo can be switched
// - dial command answered OK or ERROR
// - power-up state with timed change
`timescale 1ns/1ps
`default_nettype none
module serial_core
    import serial_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [serial_pkg::DIV_W-1:0] div,
    input wire serial_pkg::parity_t par,
    input wire logic stop2,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic txd,
    input wire logic rxd,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err
);
    typedef struct packed {
        logic tx_busy;
        logic [DIV_W-1:0] tx_cnt;
        logic [3:0] tx_left;
        logic [11:0] tx_sh;
        logic rx_busy;
        logic [DIV_W-1:0] rx_cnt;
        logic [3:0] rx_left;
        logic [10:0] rx_sh;
        logic rx_prev;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_err;
    } core_st_t;

    core_st_t s_reg;
    core_st_t s_next;
    logic [3:0] len;
    logic [3:0] rx_len;
    logic [10:0] f;

    assign len = frame_len(par, stop2);
    // receiver stops at the first stop bit, so the frame fits the 11-bit shifter
    assign rx_len = len - {3'h0, stop2};
    assign f = s_reg.rx_sh >> (4'hb - rx_len);
    assign tx_ready = !s_reg.tx_busy;
    assign txd = s_reg.tx_sh[0];
    assign rx_valid = s_reg.rx_valid;
    assign rx_data = s_reg.rx_data;
    assign rx_err = s_reg.rx_err;

    always_comb
    begin
        s_next = s_reg;
        s_next.rx_prev = rxd;
        s_next.rx_valid = 1'b0;
        if (!s_reg.tx_busy)
        begin
            if (tx_valid)
            begin
                s_next.tx_busy = 1'b1;
                s_next.tx_cnt = div - 1'b1;
                s_next.tx_left = len;
                s_next.tx_sh = {2'h3, par_bit(par, tx_data), tx_data, 1'b0};
            end
        end
        else if (s_reg.tx_cnt != '0)
            s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
        else
        begin
            s_next.tx_cnt = div - 1'b1;
            s_next.tx_sh = {1'b1, s_reg.tx_sh[11:1]};
            s_next.tx_left = s_reg.tx_left - 1'b1;
            if (s_reg.tx_left == 4'h1)
            begin
                s_next.tx_busy = 1'b0;
                s_next.tx_sh = '1;
            end
        end
        if (!s_reg.rx_busy)
        begin
            if (s_reg.rx_prev && !rxd)
            begin
                s_next.rx_busy = 1'b1;
                s_next.rx_cnt = div >> 1;
                s_next.rx_left = rx_len;
            end
        end
        else if (s_reg.rx_cnt != '0)
            s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
        else
        begin
            s_next.rx_cnt = div - 1'b1;
            s_next.rx_sh = {rxd, s_reg.rx_sh[10:1]};
            s_next.rx_left = s_reg.rx_left - 1'b1;
            if (s_reg.rx_left == 4'h1)
                s_next.rx_busy = 1'b0;
        end
        if (s_reg.rx_busy == 1'b0 && s_reg.rx_left == 4'h0 && s_reg.rx_cnt == div - 1'b1)
        begin
            s_next.rx_valid = 1'b1;
            s_next.rx_data = f[8:1];
            s_next.rx_err = f[0] || !f[rx_len - 1'b1] || (par != PAR_NONE && f[9] != par_bit(par, f[8:1]));
            s_next.rx_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.tx_sh <= '1;
            s_reg.rx_prev <= 1'b1;
        end
        else
            s_reg <= s_next;
    end
endmodule

module serial_device
    import serial_pkg::*;
#(
    parameter int MS_CYCLES = serial_pkg::MS_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    serial_if.device link,
    input wire serial_pkg::cfg_t cfg_default,
    input wire serial_pkg::mode_t mode_default,
    input wire logic incoming_call,
    input wire logic [serial_pkg::AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    output serial_pkg::pwr_mode_t pwr_mode
);
    typedef struct packed {
        logic booted;
        cfg_t cfg;
        mode_t mode;
        pwr_mode_t pwr;
        logic [31:0] ms_cnt;
        logic [15:0] ms_left;
        logic [7:0] esc;
        logic [1:0] esc_cnt;
        logic [7:0] tx_hold;
        logic tx_full;
        logic [7:0] rx_hold;
        logic rx_full;
        logic [7:0] c1;
        logic [7:0] c2;
        logic echo_pend;
        logic [7:0] echo_ch;
        logic resp_busy;
        logic resp_ok;
        logic [2:0] resp_idx;
        logic online;
        logic link_up;
        logic ring;
        logic dsr_prev;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic [31:0] rdata;
    } dev_st_t;

    dev_st_t s_reg;
    dev_st_t s_next;
    logic cts_ok;
    logic tx_ready;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_err;
    logic [IRQ_W-1:0] ev;
    logic [7:0] up;

    assign cts_ok = !s_reg.cfg.flow || !link.cts_b;
    assign tx_valid = (s_reg.resp_busy || s_reg.echo_pend || s_reg.tx_full) && cts_ok;
    assign tx_byte = s_reg.resp_busy ? resp_char(s_reg.resp_ok, s_reg.resp_idx) :
                     (s_reg.echo_pend ? s_reg.echo_ch : s_reg.tx_hold);
    assign link.rts_b = s_reg.cfg.flow && s_reg.rx_full;
    assign link.ring_indicate_out = s_reg.cfg.dce && (s_reg.cfg.ri_poll ? incoming_call : s_reg.ring);
    assign rdata = s_reg.rdata;
    assign irq = |(s_reg.irq & s_reg.mask);
    assign pwr_mode = s_reg.pwr;
    assign up = rx_data & CASE_MASK;

    serial_core core (
        .clk(clk),
        .rst_b(rst_b),
        .div(s_reg.cfg.div),
        .par(s_reg.cfg.par),
        .stop2(s_reg.cfg.stop2),
        .tx_valid(tx_valid),
        .tx_data(tx_byte),
        .tx_ready(tx_ready),
        .txd(link.txd),
        .rxd(link.rxd),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_err(rx_err)
    );

    always_comb
    begin
        s_next = s_reg;
        ev = '0;
        s_next.dsr_prev = link.dsr_b;
        if (!s_reg.booted)
        begin
            s_next.booted = 1'b1;
            s_next.cfg = cfg_default;
            s_next.cfg.div = clamp_div(cfg_default.div);
            s_next.mode = mode_default;
            s_next.pwr = mode_default.start;
            s_next.ms_left = mode_default.delay_ms;
            s_next.ms_cnt = '0;
        end
        else if (s_reg.ms_left != '0)
        begin
            s_next.ms_cnt = s_reg.ms_cnt + 1;
            if (s_reg.ms_cnt == MS_CYCLES - 1)
            begin
                s_next.ms_cnt = '0;
                s_next.ms_left = s_reg.ms_left - 1'b1;
                if (s_reg.ms_left == 16'h1)
                begin
                    s_next.pwr = s_reg.mode.next;
                    ev[IRQ_MODE] = 1'b1;
                end
            end
        end
        if (tx_valid && tx_ready)
        begin
            if (s_reg.resp_busy)
            begin
                s_next.resp_idx = s_reg.resp_idx + 1'b1;
                s_next.resp_busy = s_reg.resp_idx != resp_last(s_reg.resp_ok);
            end
            else if (s_reg.echo_pend)
                s_next.echo_pend = 1'b0;
            else
                s_next.tx_full = 1'b0;
        end
        if (rx_valid)
        begin
            ev[IRQ_ERR] = rx_err || s_reg.rx_full;
            if (!s_reg.rx_full)
            begin
                s_next.rx_full = 1'b1;
                s_next.rx_hold = rx_data;
                ev[IRQ_RX] = 1'b1;
            end
            if (s_reg.online)
            begin
                s_next.esc_cnt = (rx_data == s_reg.esc) ? s_reg.esc_cnt + 1'b1 : 2'h0;
                if (rx_data == s_reg.esc && s_reg.esc_cnt == ESC_COUNT - 1'b1)
                begin
                    s_next.online = 1'b0;
                    s_next.esc_cnt = 2'h0;
                    ev[IRQ_ESC] = 1'b1;
                end
            end
            else
            begin
                s_next.c1 = up;
                s_next.c2 = s_reg.c1;
                ev[IRQ_DIAL] = up == CH_D && s_reg.c1 == CH_T && s_reg.c2 == CH_A;
                if (s_reg.cfg.echo)
                begin
                    s_next.echo_pend = 1'b1;
                    s_next.echo_ch = rx_data;
                end
            end
        end
        if (s_reg.cfg.hs && s_reg.online && !s_reg.dsr_prev && link.dsr_b)
        begin
            ev[IRQ_DSR] = 1'b1;
            s_next.online = 1'b0;
            if (!s_reg.cfg.dsr_cmd)
                s_next.link_up = 1'b0;
        end
        s_next.rdata = '0;
        if (rd)
        begin
            case (addr)
                REG_CFG: s_next.rdata = 32'(s_reg.cfg);
                REG_DATA:
                begin
                    s_next.rdata = {24'h0, s_reg.rx_hold};
                    // a character landing in an empty buffer survives the read
                    if (s_reg.rx_full)
                        s_next.rx_full = 1'b0;
                end
                REG_STAT: s_next.rdata = {22'h0, s_reg.pwr, link.ring_indicate_out, !link.dsr_b, !link.cts_b,
                                          s_reg.link_up, s_reg.online, s_reg.resp_busy, s_reg.tx_full, s_reg.rx_full};
                REG_IRQ:
                begin
                    s_next.rdata = {25'h0, s_reg.irq};
                    s_next.irq = '0;
                end
                REG_MASK: s_next.rdata = {25'h0, s_reg.mask};
                REG_ESC: s_next.rdata = {24'h0, s_reg.esc};
                REG_CALL: s_next.rdata = {31'h0, s_reg.ring};
                REG_MODE: s_next.rdata = {12'h0, s_reg.mode};
                default: s_next.rdata = '0;
            endcase
        end
        if (wr)
        begin
            case (addr)
                REG_CFG:
                begin
                    s_next.cfg = wdata[$bits(cfg_t)-1:0];
                    s_next.cfg.div = clamp_div(wdata[DIV_W-1:0]);
                end
                REG_DATA:
                begin
                    if (!s_reg.tx_full)
                    begin
                        s_next.tx_hold = wdata[7:0];
                        s_next.tx_full = 1'b1;
                    end
                end
                REG_MASK: s_next.mask = wdata[IRQ_W-1:0];
                REG_ESC: s_next.esc = wdata[7:0];
                REG_CALL:
                begin
                    s_next.ring = wdata[CALL_RING];
                    if (wdata[CALL_RESULT] && !s_reg.resp_busy)
                    begin
                        s_next.resp_busy = 1'b1;
                        s_next.resp_ok = wdata[CALL_OK];
                        s_next.resp_idx = 3'h0;
                        s_next.online = wdata[CALL_OK];
                        s_next.link_up = wdata[CALL_OK];
                    end
                    if (wdata[CALL_HANGUP])
                    begin
                        s_next.online = 1'b0;
                        s_next.link_up = 1'b0;
                    end
                end
                REG_MODE:
                begin
                    s_next.mode = wdata[$bits(mode_t)-1:0];
                    s_next.pwr = pwr_mode_t'(wdata[1:0]);
                    s_next.ms_left = wdata[19:4];
                    s_next.ms_cnt = '0;
                end
                default: s_next.rdata = s_next.rdata;
            endcase
        end
        s_next.irq = s_next.irq | ev;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.cfg <= CFG_RST;
            s_reg.esc <= ESC_RST;
            s_reg.dsr_prev <= 1'b1;
        end
        else
            s_reg <= s_next;
    end
endmodule
`default_nettype wire

// *** design/serial_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_host
    import serial_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    serial_if.host link,
    input wire logic [serial_pkg::AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    typedef struct packed {
        cfg_t cfg;
        logic dtr;
        logic [7:0] tx_hold;
        logic tx_full;
        logic [7:0] rx_hold;
        logic rx_full;
        logic ring_prev;
        logic [IRQ_W-1:0] irq;
        logic [IRQ_W-1:0] mask;
        logic [31:0] rdata;
    } host_st_t;

    host_st_t s_reg;
    host_st_t s_next;
    logic tx_valid;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_err;

    // with flow on, send only while the device is ready to take
    assign tx_valid = s_reg.tx_full && (!s_reg.cfg.flow || !link.rts_b);
    assign link.cts_b = s_reg.cfg.flow && s_reg.rx_full;
    assign link.dsr_b = !s_reg.dtr;
    assign rdata = s_reg.rdata;
    assign irq = |(s_reg.irq & s_reg.mask);

    serial_core core (
        .clk(clk),
        .rst_b(rst_b),
        .div(s_reg.cfg.div),
        .par(s_reg.cfg.par),
        .stop2(s_reg.cfg.stop2),
        .tx_valid(tx_valid),
        .tx_data(s_reg.tx_hold),
        .tx_ready(tx_ready),
        .txd(link.rxd),
        .rxd(link.txd),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_err(rx_err)
    );

    always_comb
    begin
        s_next = s_reg;
        s_next.ring_prev = link.ring_indicate_out;
        if (tx_valid && tx_ready)
            s_next.tx_full = 1'b0;
        s_next.rdata = '0;
        if (rd)
        begin
            case (addr)
                REG_CFG: s_next.rdata = 32'(s_reg.cfg);
                REG_DATA:
                begin
                    s_next.rdata = {24'h0, s_reg.rx_hold};
                    s_next.rx_full = 1'b0;
                end
                REG_STAT: s_next.rdata = {26'h0, link.ring_indicate_out, !link.rts_b, s_reg.dtr, 1'b0,
                                          s_reg.tx_full, s_reg.rx_full};
                REG_IRQ:
                begin
                    s_next.rdata = {25'h0, s_reg.irq};
                    s_next.irq = '0;
                end
                REG_MASK: s_next.rdata = {25'h0, s_reg.mask};
                REG_LINE: s_next.rdata = {31'h0, s_reg.dtr};
                default: s_next.rdata = '0;
            endcase
        end
        if (wr)
        begin
            case (addr)
                REG_CFG:
                begin
                    s_next.cfg = wdata[$bits(cfg_t)-1:0];
                    s_next.cfg.div = clamp_div(wdata[DIV_W-1:0]);
                end
                REG_DATA:
                begin
                    if (!s_reg.tx_full)
                    begin
                        s_next.tx_hold = wdata[7:0];
                        s_next.tx_full = 1'b1;
                    end
                end
                REG_MASK: s_next.mask = wdata[IRQ_W-1:0];
                REG_LINE: s_next.dtr = wdata[0];
                default: s_next.mask = s_next.mask;
            endcase
        end
        if (rx_valid)
        begin
            if (!s_reg.rx_full)
            begin
                s_next.rx_full = 1'b1;
                s_next.rx_hold = rx_data;
            end
            s_next.irq[IRQ_RX] = s_next.irq[IRQ_RX] | !s_reg.rx_full;
            s_next.irq[IRQ_ERR] = s_next.irq[IRQ_ERR] | rx_err | s_reg.rx_full;
        end
        if (link.ring_indicate_out && !s_reg.ring_prev)
            s_next.irq[IRQ_RING] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_reg <= '0;
            s_reg.cfg <= CFG_RST;
        end
        else
            s_reg <= s_next;
    end
endmodule
`default_nettype wire

// *** verif/serial_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_link_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic txd,
    input wire logic rxd,
    input wire logic rts_b,
    input wire logic cts_b,
    input wire logic dsr_b,
    input wire logic ring_indicate_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_lines_idle: assert property ($rose(rst_b) |-> txd && rxd && !rts_b && !cts_b && dsr_b)
        else $error("serial lines not idle after reset");
    a_ring_idle: assert property ($rose(rst_b) |-> !ring_indicate_out)
        else $error("ring active after reset");
    a_tx_low_bit: assert property ($fell(txd) |-> (!txd) [*8])
        else $error("txd low bit too short");
    a_tx_high_bit: assert property ($rose(txd) |-> txd [*8])
        else $error("txd high bit too short");
    a_rx_low_bit: assert property ($fell(rxd) |-> (!rxd) [*8])
        else $error("rxd low bit too short");
    a_rx_high_bit: assert property ($rose(rxd) |-> rxd [*8])
        else $error("rxd high bit too short");
    a_rts_at_stop: assert property ($rose(rts_b) |-> rxd && $past(rxd))
        else $error("rts raised outside stop bit");
    a_cts_at_stop: assert property ($rose(cts_b) |-> txd && $past(txd))
        else $error("cts raised outside stop bit");
    c_rts_rise: cover property ($rose(rts_b));
    c_cts_rise: cover property ($rose(cts_b));
    c_ring_rise: cover property ($rose(ring_indicate_out));
endmodule
`default_nettype wire

// *** verif/host_serial_port_flow_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_flow_bench;
    import serial_pkg::*;
    // fastest legal bit time, flow on, communication role, echo off
    localparam cfg_t CFG_DEF = cfg_t'(27'h0600105);
    // start connectable, after 200 ms go discoverable
    localparam mode_t MODE_DEF = mode_t'(20'h00c89);
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic d_wr = 1'b0;
    logic d_rd = 1'b0;
    logic h_wr = 1'b0;
    logic h_rd = 1'b0;
    logic incoming_call = 1'b0;
    logic [31:0] d_rdata;
    logic [31:0] h_rdata;
    logic d_irq;
    logic h_irq;
    pwr_mode_t pwr;
    int bad_count = 0;
    int checks = 0;
    serial_if link();
    serial_device #(.MS_CYCLES(10)) u_serial_device (.clk(clk), .rst_b(rst_b), .link(link.device),
        .cfg_default(CFG_DEF), .mode_default(MODE_DEF), .incoming_call(incoming_call), .addr(addr),
        .wdata(wdata), .wr(d_wr), .rd(d_rd), .rdata(d_rdata), .irq(d_irq), .pwr_mode(pwr));
    serial_host u_serial_host (.clk(clk), .rst_b(rst_b), .link(link.host), .addr(addr), .wdata(wdata),
        .wr(h_wr), .rd(h_rd), .rdata(h_rdata), .irq(h_irq));
    serial_link_asserts u_serial_link_asserts (.clk(clk), .rst_b(rst_b), .txd(link.txd), .rxd(link.rxd),
        .rts_b(link.rts_b), .cts_b(link.cts_b), .dsr_b(link.dsr_b), .ring_indicate_out(link.ring_indicate_out));
    always #2 clk = ~clk;
    task automatic results();
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask
    // h selects the host end, otherwise the device end
    task automatic wr(input logic h, input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        d_wr <= !h;
        h_wr <= h;
        @(posedge clk);
        d_wr <= 1'b0;
        h_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic h, input logic [AW-1:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        @(posedge clk);
        addr <= a;
        d_rd <= !h;
        h_rd <= h;
        @(posedge clk);
        d_rd <= 1'b0;
        h_rd <= 1'b0;
        #1;
        cmp((h ? h_rdata : d_rdata) & m, e);
    endtask
    task automatic h2d(input logic [7:0] c);
        wr(1'b1, REG_DATA, {24'h0, c});
        for (int i = 0; i < 4000 && link.rts_b !== 1'b1; i++) @(posedge clk);
        cmp_bit(link.rts_b, 1'b1);
        rd(1'b0, REG_DATA, {24'h0, c});
        cmp_bit(link.rts_b, 1'b0);
    endtask
    task automatic wait_cts();
        for (int i = 0; i < 4000 && link.cts_b !== 1'b1; i++) @(posedge clk);
        cmp_bit(link.cts_b, 1'b1);
    endtask
    task automatic d2h(input logic [7:0] c);
        wait_cts();
        rd(1'b1, REG_DATA, {24'h0, c});
    endtask
    task automatic reset_state();
        cmp({30'h0, pwr}, 32'h1);
        rd(1'b0, REG_CFG, 32'h0060_0105);
        rd(1'b1, REG_STAT, 32'h10);
        wr(1'b1, REG_CFG, 32'h0020_0105);
    endtask
    task automatic rx_irq_mode();
        wr(1'b0, REG_MASK, 32'h0);
        h2d(8'ha5);
        cmp_bit(d_irq, 1'b0);
        cmp({30'h0, pwr}, 32'h2);
        wr(1'b0, REG_MASK, 32'h7f);
        cmp_bit(d_irq, 1'b1);
        rd(1'b0, REG_IRQ, 32'h21);
        cmp_bit(d_irq, 1'b0);
    endtask
    task automatic tx_held_by_cts();
        wr(1'b0, REG_DATA, 32'h3c);
        wait_cts();
        wr(1'b0, REG_DATA, 32'h5a);
        repeat (3000) @(posedge clk);
        rd(1'b1, REG_DATA, 32'h3c);
        d2h(8'h5a);
        rd(1'b1, REG_IRQ, 32'h1);
    endtask
    task automatic dial();
        h2d(8'h61);
        h2d(8'h54);
        h2d(8'h64);
        rd(1'b0, REG_IRQ, 32'h5);
        wr(1'b0, REG_CALL, 32'h6);
        d2h(8'h4f);
        d2h(8'h4b);
        d2h(8'h0d);
        d2h(8'h0a);
        rd(1'b0, REG_STAT, 32'h18, 32'h18);
    endtask
    task automatic dsr_drop();
        wr(1'b1, REG_LINE, 32'h1);
        cmp_bit(link.dsr_b, 1'b0);
        wr(1'b0, REG_CFG, 32'h0160_0001);
        rd(1'b0, REG_CFG, 32'h0160_0105);
        wr(1'b1, REG_LINE, 32'h0);
        for (int i = 0; i < 50 && d_irq !== 1'b1; i++) @(posedge clk);
        rd(1'b0, REG_STAT, 32'h0, 32'h18);
        rd(1'b0, REG_IRQ, 32'h10);
    endtask
    task automatic escape();
        wr(1'b0, REG_ESC, 32'h7e);
        wr(1'b0, REG_CALL, 32'h6);
        repeat (3) h2d(8'h7e);
        rd(1'b0, REG_STAT, 32'h10, 32'h18);
        rd(1'b0, REG_IRQ, 32'h9);
    endtask
    task automatic ring();
        wr(1'b0, REG_CALL, 32'h1);
        cmp_bit(link.ring_indicate_out, 1'b1);
        repeat (4) @(posedge clk);
        rd(1'b1, REG_IRQ, 32'h41);
        wr(1'b0, REG_CALL, 32'h0);
        cmp_bit(link.ring_indicate_out, 1'b0);
        wr(1'b0, REG_CFG, 32'h0260_0105);
        @(posedge clk);
        incoming_call <= 1'b1;
        @(posedge clk);
        #1;
        cmp_bit(link.ring_indicate_out, 1'b1);
        wr(1'b0, REG_CFG, 32'h0220_0105);
        cmp_bit(link.ring_indicate_out, 1'b0);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        reset_state();
        rx_irq_mode();
        tx_held_by_cts();
        dial();
        dsr_drop();
        escape();
        ring();
        results();
    end
    initial
    begin
        #400_000;
        bad_count++;
        $display("CHECK FAILED %0t timeout", $time);
        results();
    end
endmodule
`default_nettype wire
